// *** common/mhb_pkg.sv ***
`default_nettype none
package mhb_pkg;
    localparam int NUM_MACS     = 2;
    localparam int TABLE_DEPTH  = 4;

    // register pointers inside each mac's host space
    localparam logic [9:0] OFF_MGMT_CFG = 10'h340;
    localparam logic [9:0] OFF_UNI0     = 10'h380;
    localparam logic [9:0] OFF_UNI1     = 10'h384;
    localparam logic [9:0] OFF_TAB0     = 10'h388;
    localparam logic [9:0] OFF_TAB1     = 10'h38C;
    localparam logic [9:0] OFF_FMODE    = 10'h390;

    localparam int PTR_SEL_BIT  = 9;
    localparam int TAB_IDX_LSB  = 16;
    localparam int TAB_RNW_BIT  = 23;
    localparam int MGMT_EN_BIT  = 6;
    localparam int MGMT_DIV_W   = 6;
    localparam int PROMISC_BIT  = 31;

    localparam logic [31:0] RST_WORD   = 32'h00000000;
    localparam logic [31:0] MASK_MGMT  = 32'h0000007F;
    localparam logic [31:0] MASK_UNI1  = 32'h0000FFFF;
    localparam logic [31:0] MASK_TAB1  = 32'h0083FFFF;
    localparam logic [31:0] MASK_FMODE = 32'h80000000;

    // management frame layout, sent msb first
    localparam logic [1:0]  MDIO_OP_RD    = 2'b10;
    localparam logic [1:0]  MDIO_OP_WR    = 2'b01;
    localparam logic [31:0] MDIO_PREAMBLE = 32'hFFFFFFFF;
    localparam logic [1:0]  MDIO_START    = 2'b01;
    localparam logic [1:0]  MDIO_TA_WR    = 2'b10;
    localparam logic [1:0]  MDIO_TA_RD    = 2'b11;
    localparam logic [5:0]  MDIO_LAST_BIT = 6'd63;
    localparam logic [5:0]  MDIO_TURN_BIT = 6'd46;
    localparam logic [5:0]  MDIO_DATA_BIT = 6'd48;

    // controller registers on the ahb side
    localparam logic [7:0] HOFF_CMD      = 8'h00;
    localparam logic [7:0] HOFF_WDATA    = 8'h04;
    localparam logic [7:0] HOFF_RDATA    = 8'h08;
    localparam logic [7:0] HOFF_RDATA_HI = 8'h0C;
    localparam logic [7:0] HOFF_STATUS   = 8'h10;
    localparam int CMD_MGMT_BIT  = 10;
    localparam int CMD_MAC_BIT   = 11;
    localparam int CMD_OP_LSB    = 12;
    localparam int CMD_TABRD_BIT = 14;

    typedef enum logic [2:0] {
        HST_IDLE, HST_CFG_WR, HST_CFG_RD, HST_TAB_LO, HST_TAB_HI,
        HST_MDIO_REQ, HST_MDIO_GAP, HST_MDIO_WAIT
    } mhb_host_state_t;
endpackage : mhb_pkg
`default_nettype wire

// *** common/mhb_if.sv ***
`default_nettype none
interface mhb_if (input wire logic i_clk);
    logic        dcr_path_select;
    logic        host_mgmt_select;
    logic [9:0]  host_reg_pointer;
    logic        second_mac_select;
    logic [1:0]  host_operation_code;
    logic [31:0] host_write_word;
    logic [31:0] host_read_word;
    logic        host_transfer_request;
    logic        mgmt_transfer_done;

    modport dev (
        input  dcr_path_select, host_mgmt_select, host_reg_pointer, second_mac_select,
        input  host_operation_code, host_write_word, host_transfer_request,
        output host_read_word, mgmt_transfer_done
    );
    modport host (
        output dcr_path_select, host_mgmt_select, host_reg_pointer, second_mac_select,
        output host_operation_code, host_write_word, host_transfer_request,
        input  host_read_word, mgmt_transfer_done
    );
endinterface : mhb_if
`default_nettype wire

// *** hdl/mhb_mdio_engine.sv ***
`default_nettype none
module mhb_mdio_engine
    import mhb_pkg::*;
#(
    parameter int DIV_W = MGMT_DIV_W
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_start,
    input  wire logic [1:0]       i_op,
    input  wire logic [4:0]       i_phyad,
    input  wire logic [4:0]       i_regad,
    input  wire logic [15:0]      i_wdata,
    input  wire logic [DIV_W-1:0] i_div,
    input  wire logic             i_mdio_in,
    output logic                  o_busy,
    output logic                  o_done,
    output logic [15:0]           o_rdata,
    output logic                  o_mdc,
    output logic                  o_mdio_out,
    output logic                  o_mdio_oe
);
    logic [DIV_W-1:0] div_cnt_reg;
    logic [63:0]      shift_reg;
    logic [5:0]       bit_cnt_reg;
    logic             is_rd_reg;
    logic             sync1_reg;
    logic             sync2_reg;
    logic             tick;
    logic [63:0]      frame;

    assign tick  = o_busy && (div_cnt_reg == i_div);
    assign frame = {MDIO_PREAMBLE, MDIO_START, i_op, i_phyad, i_regad,
                    (i_op == MDIO_OP_RD) ? MDIO_TA_RD : MDIO_TA_WR,
                    (i_op == MDIO_OP_RD) ? 16'hFFFF : i_wdata};

    // half-period enable derived from the host clock
    always_ff @(posedge i_clk or negedge i_rstn) begin // see R9
        if (!i_rstn) begin
            div_cnt_reg <= '0;
        end else if (i_start || tick) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= i_mdio_in;
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_busy      <= 1'b0;
            o_done      <= 1'b0;
            o_rdata     <= 16'h0000;
            o_mdc       <= 1'b0;
            o_mdio_out  <= 1'b0;
            o_mdio_oe   <= 1'b0;
            shift_reg   <= 64'h0000000000000000;
            bit_cnt_reg <= 6'd0;
            is_rd_reg   <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_busy) begin
                o_busy      <= 1'b1;
                o_mdc       <= 1'b0;
                shift_reg   <= frame;
                bit_cnt_reg <= 6'd0;
                is_rd_reg   <= (i_op == MDIO_OP_RD);
                o_mdio_out  <= frame[63];
                o_mdio_oe   <= 1'b1;
            end else if (tick) begin
                o_mdc <= ~o_mdc;
                if (!o_mdc) begin
                    // the phy drives data on the falling edge, so sample on the rising one
                    if (is_rd_reg && bit_cnt_reg >= MDIO_DATA_BIT) begin // see R17
                        o_rdata <= {o_rdata[14:0], sync2_reg};
                    end
                end else if (bit_cnt_reg == MDIO_LAST_BIT) begin
                    o_busy     <= 1'b0;
                    o_done     <= 1'b1;
                    o_mdio_oe  <= 1'b0;
                    o_mdio_out <= 1'b0;
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 6'd1;
                    shift_reg   <= {shift_reg[62:0], 1'b0};
                    o_mdio_out  <= shift_reg[62];
                    o_mdio_oe   <= !is_rd_reg || ((bit_cnt_reg + 6'd1) < MDIO_TURN_BIT);
                end
            end
        end
    end
endmodule : mhb_mdio_engine
`default_nettype wire

// *** hdl/mhb_dev_port.sv ***
// Behaviour
// R1: integrator ties dcr path select low
// R2: decode type from mac, mgmt select, bit9; code decodes from dcr path select, mgmt select, bit9, not mac
// R3: opcode bit1 is active-low write, bit0 ignored
// R4: full ten-bit pointer selects target register
// R5: second mac select routes to mac one
// R6: read data appears edge after pointer
// R7: host holds config read select even cycles
// R8: host clock at most 125 MHz
// R9: management clock divided from host clock
// R10: filter accesses use config access timing
// R11: table write: word0 then word1 with rnw 0
// R12: table read: write word1 with rnw 1
// R13: table read returns low then high word
// R14: disabled management completes at once, ignored
// R15: opcode copied into frame opcode field
// R16: pointer bits split into phy, register address
// R17: low sixteen data bits carried both ways
// R18: request pulse starts; ignored while busy
// R19: done low while busy, read data valid after
// R20: host stays off the bus until done
// R21: word1 holds index 17:16, rnw bit 23
// R22: all host inputs sampled on rising edge
`default_nettype none
module mhb_dev_port
    import mhb_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    mhb_if.dev              bus,
    input  wire logic       i_mdio_in,
    output logic            o_mdc,
    output logic            o_mdio_out,
    output logic            o_mdio_oe,
    output logic [1:0]      o_promisc
);
    logic [31:0] mgmt_cfg_reg [NUM_MACS];
    logic [31:0] uni0_reg     [NUM_MACS];
    logic [31:0] uni1_reg     [NUM_MACS];
    logic [31:0] tab0_reg     [NUM_MACS];
    logic [31:0] tab1_reg     [NUM_MACS];
    logic [31:0] fmode_reg    [NUM_MACS];
    logic [47:0] table_reg    [NUM_MACS][TABLE_DEPTH];

    logic [31:0] rd_word_reg;
    logic [1:0]  fetch_stage_reg;
    logic        fetch_mac_reg;
    logic        mdio_mac_reg;
    logic        mdio_rd_reg;

    logic        host_en;
    logic        mac;
    logic        cfg_acc;
    logic        cfg_wr;
    logic        cfg_rd;
    logic        mdio_req;
    logic        mdio_start;
    logic [1:0]  tab_idx;
    logic        tab_fetch;
    logic [31:0] wdata;
    logic        eng_busy;
    logic        eng_done;
    logic [15:0] eng_rdata;

    // dcr path off: host bus in use
    assign host_en  = !bus.dcr_path_select;                                      // see R1
    assign mac      = bus.second_mac_select;                                      // see R5
    assign cfg_acc  = host_en && !bus.host_mgmt_select
                      && bus.host_reg_pointer[PTR_SEL_BIT];                        // see R2
    assign cfg_wr   = cfg_acc && !bus.host_operation_code[1];                      // see R3
    assign cfg_rd   = cfg_acc && bus.host_operation_code[1];                       // see R3
    assign mdio_req = host_en && bus.host_mgmt_select && bus.host_transfer_request; // see R2
    assign wdata    = bus.host_write_word;
    assign tab_idx  = wdata[TAB_IDX_LSB +: 2];                                    // see R21
    assign tab_fetch = cfg_wr && (bus.host_reg_pointer == OFF_TAB1) && wdata[TAB_RNW_BIT]; // see R12

    // busy engine or disabled mac: request dropped
    assign mdio_start = mdio_req && !eng_busy
                        && mgmt_cfg_reg[mac][MGMT_EN_BIT];                         // see R14 see R18

    assign bus.mgmt_transfer_done = !eng_busy && !eng_done;                       // see R19 see R14
    assign bus.host_read_word     = rd_word_reg;
    assign o_promisc = {fmode_reg[1][PROMISC_BIT], fmode_reg[0][PROMISC_BIT]};

    function automatic logic [31:0] reg_pick(input logic m, input logic [9:0] p);
        logic [31:0] v;
        v = RST_WORD;
        case (p) // see R4
            OFF_MGMT_CFG: v = mgmt_cfg_reg[m];
            OFF_UNI0:     v = uni0_reg[m];
            OFF_UNI1:     v = uni1_reg[m];
            OFF_TAB0:     v = tab0_reg[m];
            OFF_TAB1:     v = tab1_reg[m];
            OFF_FMODE:    v = fmode_reg[m];
            default:      v = RST_WORD;
        endcase
        return v;
    endfunction : reg_pick

    // plain configuration and filter words
    always_ff @(posedge i_clk or negedge i_rstn) begin // see R22
        if (!i_rstn) begin
            for (int i = 0; i < NUM_MACS; i++) begin
                mgmt_cfg_reg[i] <= RST_WORD;
                uni0_reg[i]     <= RST_WORD;
                uni1_reg[i]     <= RST_WORD;
                fmode_reg[i]    <= RST_WORD;
            end
        end else if (cfg_wr) begin // see R10
            case (bus.host_reg_pointer) // see R4 see R5
                OFF_MGMT_CFG: mgmt_cfg_reg[mac] <= wdata & MASK_MGMT;
                OFF_UNI0:     uni0_reg[mac]     <= wdata;
                OFF_UNI1:     uni1_reg[mac]     <= wdata & MASK_UNI1;
                OFF_FMODE:    fmode_reg[mac]    <= wdata & MASK_FMODE;
                default:      ;
            endcase
        end
    end

    // general address table behind its two staging words
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < NUM_MACS; i++) begin
                tab0_reg[i] <= RST_WORD;
                tab1_reg[i] <= RST_WORD;
                for (int j = 0; j < TABLE_DEPTH; j++) begin
                    table_reg[i][j] <= 48'h000000000000;
                end
            end
        end else if (cfg_wr) begin
            if (bus.host_reg_pointer == OFF_TAB0) begin
                tab0_reg[mac] <= wdata;
            end else if (bus.host_reg_pointer == OFF_TAB1) begin
                if (wdata[TAB_RNW_BIT]) begin // see R12
                    tab0_reg[mac] <= table_reg[mac][tab_idx][31:0];
                    tab1_reg[mac] <= (wdata & MASK_TAB1 & ~MASK_UNI1)
                                     | {16'h0000, table_reg[mac][tab_idx][47:32]};
                end else begin // see R11 see R21
                    tab1_reg[mac]           <= wdata & MASK_TAB1;
                    table_reg[mac][tab_idx] <= {wdata[15:0], tab0_reg[mac]};
                end
            end
        end
    end

    // two-word return sequence after a table fetch
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fetch_stage_reg <= 2'd0;
            fetch_mac_reg   <= 1'b0;
        end else if (tab_fetch) begin
            fetch_stage_reg <= 2'd1;
            fetch_mac_reg   <= mac;
        end else if (fetch_stage_reg == 2'd1) begin
            fetch_stage_reg <= 2'd2;
        end else begin
            fetch_stage_reg <= 2'd0;
        end
    end

    // every read result lands here
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_word_reg <= RST_WORD;
        end else if (cfg_rd) begin
            rd_word_reg <= reg_pick(mac, bus.host_reg_pointer); // see R6 see R10
        end else if (fetch_stage_reg == 2'd1) begin
            rd_word_reg <= tab0_reg[fetch_mac_reg]; // see R13
        end else if (fetch_stage_reg == 2'd2) begin
            rd_word_reg <= {16'h0000, tab1_reg[fetch_mac_reg][15:0]}; // see R13
        end else if (eng_done && mdio_rd_reg) begin
            rd_word_reg <= {16'h0000, eng_rdata}; // see R17 see R19
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mdio_mac_reg <= 1'b0;
            mdio_rd_reg  <= 1'b0;
        end else if (mdio_start) begin
            mdio_mac_reg <= mac;
            mdio_rd_reg  <= (bus.host_operation_code == MDIO_OP_RD);
        end
    end

    // one engine is shared; the divider follows the mac that owns the transfer
    mhb_mdio_engine #(
        .DIV_W      (MGMT_DIV_W)
    ) u_engine (
        .i_clk      (i_clk),
        .i_rstn     (i_rstn),
        .i_start    (mdio_start),
        .i_op       (bus.host_operation_code),          // see R15
        .i_phyad    (bus.host_reg_pointer[9:5]),        // see R16
        .i_regad    (bus.host_reg_pointer[4:0]),        // see R16
        .i_wdata    (wdata[15:0]),                      // see R17
        .i_div      (mgmt_cfg_reg[mdio_mac_reg][MGMT_DIV_W-1:0]), // see R9
        .i_mdio_in  (i_mdio_in),
        .o_busy     (eng_busy),
        .o_done     (eng_done),
        .o_rdata    (eng_rdata),
        .o_mdc      (o_mdc),
        .o_mdio_out (o_mdio_out),
        .o_mdio_oe  (o_mdio_oe)
    );
endmodule : mhb_dev_port
`default_nettype wire

// *** hdl/mhb_host_port.sv ***
`default_nettype none
module mhb_host_port
    import mhb_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata,
    mhb_if.host              bus
);
    mhb_host_state_t state_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_hi_reg;
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic        mgmt_reg;
    logic [9:0]  ptr_reg;
    logic        mac_reg;
    logic [1:0]  op_reg;
    logic        req_reg;
    logic        mdio_rd_reg;
    logic        tab_rd_reg;
    logic        addr_ok;
    logic        cmd_go;
    logic [31:0] status;

    assign addr_ok = i_hsel && i_htrans[1] && i_hready;
    // a command written while busy is dropped
    assign cmd_go  = wr_pend_reg && (wr_addr_reg == HOFF_CMD) && (state_reg == HST_IDLE); // see R20
    assign status  = {30'h00000000, bus.mgmt_transfer_done, state_reg != HST_IDLE};

    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    assign bus.dcr_path_select       = 1'b0; // see R1
    assign bus.host_mgmt_select      = mgmt_reg;
    assign bus.host_reg_pointer      = ptr_reg;
    assign bus.second_mac_select     = mac_reg;
    assign bus.host_operation_code   = op_reg;
    assign bus.host_write_word       = wdata_reg;
    assign bus.host_transfer_request = req_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            o_hrdata    <= 32'h00000000;
        end else if (addr_ok) begin
            wr_pend_reg <= i_hwrite;
            wr_addr_reg <= i_haddr[7:0];
            case (i_haddr[7:0])
                HOFF_WDATA:    o_hrdata <= wdata_reg;
                HOFF_RDATA:    o_hrdata <= rdata_reg;
                HOFF_RDATA_HI: o_hrdata <= rdata_hi_reg;
                HOFF_STATUS:   o_hrdata <= status;
                default:       o_hrdata <= 32'h00000000;
            endcase
        end else if (i_hready) begin
            wr_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wdata_reg <= 32'h00000000;
        end else if (wr_pend_reg && wr_addr_reg == HOFF_WDATA && state_reg == HST_IDLE) begin
            wdata_reg <= i_hwdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg    <= HST_IDLE;
            mgmt_reg     <= 1'b1;
            ptr_reg      <= 10'h000;
            mac_reg      <= 1'b0;
            op_reg       <= 2'b11;
            req_reg      <= 1'b0;
            mdio_rd_reg  <= 1'b0;
            rdata_reg    <= 32'h00000000;
            rdata_hi_reg <= 32'h00000000;
        end else begin
            req_reg <= 1'b0;
            case (state_reg)
                HST_IDLE: begin
                    if (cmd_go) begin
                        ptr_reg <= i_hwdata[9:0];                            // see R4
                        mac_reg <= i_hwdata[CMD_MAC_BIT];                    // see R5
                        op_reg  <= i_hwdata[CMD_OP_LSB +: 2];
                        if (i_hwdata[CMD_MGMT_BIT]) begin
                            mgmt_reg    <= 1'b1;                             // see R15
                            req_reg     <= 1'b1;                             // see R18
                            mdio_rd_reg <= i_hwdata[CMD_OP_LSB + 1];
                            state_reg   <= HST_MDIO_REQ;
                        end else begin
                            mgmt_reg  <= 1'b0;                               // see R3
                            state_reg <= i_hwdata[CMD_OP_LSB + 1] ? HST_CFG_RD : HST_CFG_WR;
                        end
                    end
                end
                HST_CFG_WR: begin // see R10 see R11
                    mgmt_reg  <= 1'b1;
                    state_reg <= (ptr_reg == OFF_TAB1 && tab_rd_reg) ? HST_CFG_RD : HST_IDLE; // see R12
                end
                HST_CFG_RD: state_reg <= mgmt_reg ? HST_TAB_LO : HST_TAB_HI; // see R13
                HST_TAB_LO: begin
                    rdata_reg <= bus.host_read_word;                         // see R13
                    state_reg <= HST_TAB_HI;
                end
                HST_TAB_HI: begin
                    // second of two low-select cycles for a plain read
                    mgmt_reg <= 1'b1;                                        // see R7
                    if (mgmt_reg) begin
                        rdata_hi_reg <= bus.host_read_word;                  // see R13
                    end else begin
                        rdata_reg <= bus.host_read_word;                     // see R6
                    end
                    state_reg <= HST_IDLE;
                end
                HST_MDIO_REQ: state_reg <= HST_MDIO_GAP;
                HST_MDIO_GAP: state_reg <= HST_MDIO_WAIT;
                HST_MDIO_WAIT: begin
                    if (bus.mgmt_transfer_done) begin // see R19 see R20
                        if (mdio_rd_reg) begin
                            rdata_reg <= bus.host_read_word;
                        end
                        state_reg <= HST_IDLE;
                    end
                end
                default: state_reg <= HST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tab_rd_reg <= 1'b0;
        end else if (cmd_go) begin
            tab_rd_reg <= i_hwdata[CMD_TABRD_BIT];
        end
    end
endmodule : mhb_host_port
`default_nettype wire

// *** tb/mhb_monitor.sv ***
`default_nettype none
module mhb_monitor (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        dcr_path_select,
    input  wire logic        host_mgmt_select,
    input  wire logic [1:0]  host_operation_code,
    input  wire logic [31:0] host_read_word,
    input  wire logic        host_transfer_request,
    input  wire logic        mgmt_transfer_done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    a_path_tied_low: assert property (dcr_path_select == 1'b0)
        else $error("path select high");
    a_req_one_pulse: assert property (host_transfer_request |=> !host_transfer_request)
        else $error("long request");
    a_req_mdio_code: assert property (host_transfer_request |-> host_mgmt_select && ^host_operation_code)
        else $error("bad mdio request");
    a_read_even_hold: assert property ($fell(host_mgmt_select) && host_operation_code[1]
        |=> !host_mgmt_select ##1 host_mgmt_select) else $error("odd read hold");
    a_write_one_cycle: assert property ($fell(host_mgmt_select) && !host_operation_code[1]
        |=> host_mgmt_select) else $error("write select too long");
    a_done_after_req: assert property ($fell(mgmt_transfer_done) |-> $past(host_transfer_request))
        else $error("done fell unasked");
    a_busy_bus_locked: assert property (!mgmt_transfer_done |-> host_mgmt_select && !host_transfer_request)
        else $error("bus used while busy");
    a_word_held_busy: assert property (!mgmt_transfer_done |-> $stable(host_read_word))
        else $error("read word moved");
    a_mdio_completes: assert property ($fell(mgmt_transfer_done) |-> ##[1:1000] mgmt_transfer_done)
        else $error("mdio never done");
endmodule : mhb_monitor
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench
    import mhb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] RD_PAT = 16'hA5C3;
    logic        i_clk = 1'b0;
    logic        i_rstn;
    logic        hwrite = 1'b0;
    logic        hready, mdc, mdo, moe, hresp;
    logic        mq = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [1:0]  promisc;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic [17:0] sh = 18'h0;
    logic [63:0] fr = 64'h0;
    int          mismatches = 0;
    int          tests_run = 0;
    always #4 i_clk = ~i_clk;
    mhb_if bus (.i_clk);
    mhb_host_port i_mhb_host_port (.i_clk, .i_rstn, .i_hsel(1'b1), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready),
        .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .bus);
    mhb_dev_port i_mhb_dev_port (.i_clk, .i_rstn, .bus, .i_mdio_in(sh[17]),
        .o_mdc(mdc), .o_mdio_out(mdo), .o_mdio_oe(moe), .o_promisc(promisc));
    mhb_monitor i_mhb_monitor (.i_clk, .i_rstn, .dcr_path_select(bus.dcr_path_select),
        .host_mgmt_select(bus.host_mgmt_select), .host_operation_code(bus.host_operation_code),
        .host_read_word(bus.host_read_word), .host_transfer_request(bus.host_transfer_request),
        .mgmt_transfer_done(bus.mgmt_transfer_done));
    // phy stand-in
    always @(posedge i_clk) begin
        mq <= mdc;
        if (moe)
            sh <= {2'b11, RD_PAT};
        else if (mdc && !mq)
            sh <= {sh[16:0], 1'b0};
        if (mdc && !mq && moe)
            fr <= {fr[62:0], mdo};
    end
    task automatic report_and_stop();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge i_clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge i_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : ahb
    function automatic logic [31:0] cw(input logic [1:0] op, input logic m, g, input logic [9:0] p, input logic f);
        return {17'h0, f, op, m, g, p};
    endfunction : cw
    task automatic cmd(input logic [31:0] d, input logic [31:0] c);
        int n = 0;
        ahb(1'b1, HOFF_WDATA, d);
        ahb(1'b1, HOFF_CMD, c);
        do begin
            ahb(1'b0, HOFF_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 400);
        chk({30'h0, hresp, q[0]}, 32'h0);
    endtask : cmd
    task automatic rd(input logic m, input logic [9:0] p);
        cmd(32'h0, cw(2'b11, m, 1'b0, p, 1'b0));
        ahb(1'b0, HOFF_RDATA, 32'h0);
    endtask : rd
    task automatic t_cfg();
        for (int m = 0; m < 2; m++) begin
            cmd(32'h12345670 | 32'(m), cw(2'b01, 1'(m), 1'b0, OFF_UNI0, 1'b0));
            cmd(32'hFFFFFFFF, cw(2'b00, 1'(m), 1'b0, OFF_UNI1, 1'b0));
        end
        cmd(32'hFFFFFFFF, cw(2'b00, 1'b0, 1'b0, OFF_UNI0 & 10'h1FF, 1'b0));
        for (int m = 0; m < 2; m++) begin
            rd(1'(m), OFF_UNI0);
            chk(q, 32'h12345670 | 32'(m));
            rd(1'(m), OFF_UNI1);
            chk(q, 32'h0000FFFF);
        end
        cmd(32'hFFFFFFFF, cw(2'b00, 1'b1, 1'b0, OFF_FMODE, 1'b0));
        chk({30'h0, promisc}, 32'h00000002);
        rd(1'b1, OFF_FMODE);
        chk(q, 32'h80000000);
    endtask : t_cfg
    task automatic t_tab();
        for (int i = 0; i < 4; i++) begin
            cmd(32'hC0DE0000 | 32'(i), cw(2'b00, 1'b0, 1'b0, OFF_TAB0, 1'b0));
            cmd({14'h0, 2'(i), 16'hBEE0 | 16'(i)}, cw(2'b00, 1'b0, 1'b0, OFF_TAB1, 1'b0));
        end
        for (int i = 3; i >= 0; i--) begin
            cmd({9'h1, 5'h0, 2'(i), 16'h0}, cw(2'b00, 1'b0, 1'b0, OFF_TAB1, 1'b1));
            ahb(1'b0, HOFF_RDATA, 32'h0);
            chk(q, 32'hC0DE0000 | 32'(i));
            ahb(1'b0, HOFF_RDATA_HI, 32'h0);
            chk(q, {16'h0, 16'hBEE0 | 16'(i)});
        end
    endtask : t_tab
    task automatic t_mdio();
        cmd(32'h0, cw(MDIO_OP_WR, 1'b0, 1'b1, 10'h3FF, 1'b0));
        chk(q, 32'h00000002);
        chk(fr[31:0], 32'h0);
        cmd(32'h00000043, cw(2'b00, 1'b0, 1'b0, OFF_MGMT_CFG, 1'b0));
        cmd(32'hFFFF9A5B, cw(MDIO_OP_WR, 1'b0, 1'b1, {5'h15, 5'h0A}, 1'b0));
        chk(fr[63:32], 32'hFFFFFFFF);
        chk(fr[31:0], {2'b01, 2'b01, 5'h15, 5'h0A, 2'b10, 16'h9A5B});
        cmd(32'h0, cw(MDIO_OP_RD, 1'b0, 1'b1, {5'h03, 5'h11}, 1'b0));
        chk(32'(fr[13:0]), {18'h0, 2'b01, 2'b10, 5'h03, 5'h11});
        ahb(1'b0, HOFF_RDATA, 32'h0);
        chk(q, {16'h0, RD_PAT});
    endtask : t_mdio
    initial begin
        i_rstn <= 1'b0;
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_cfg();
        t_tab();
        t_mdio();
        report_and_stop();
    end
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
